// >>> spicm_cfg.svh
// Constants for the SPI client block with host select fallback.
`ifndef SPICM_CFG_SVH
`define SPICM_CFG_SVH

// ==========================================================================
// Register indices (byte address is four times the index)
`define SPICM_IDX_CTRL_FIRST  6'h00
`define SPICM_IDX_CTRL_SECOND 6'h01
`define SPICM_IDX_FLAGS       6'h03
`define SPICM_IDX_DATA        6'h04
`define SPICM_IDX_PIN_DIR     6'h05

// ==========================================================================
// Field positions
`define SPICM_BIT_ENABLE      0
`define SPICM_BIT_HOST        5
`define SPICM_BIT_ORDER       6
`define SPICM_BIT_MODE_LO     0
`define SPICM_BIT_SEL_DISABLE 2
`define SPICM_BIT_WAIT_RX     6
`define SPICM_BIT_BUF_EN      7
`define SPICM_BIT_FLAG_HI     7
`define SPICM_BIT_FLAG_MID    6
`define SPICM_BIT_FLAG_DRE    5
`define SPICM_BIT_SEL_OUT     0
`define SPICM_BIT_MISO_OUT    1

// ==========================================================================
// Reset values and writable masks
`define SPICM_RST_CTRL        8'h00
`define SPICM_RST_PIN_DIR     2'h0
`define SPICM_MASK_CTRL_FIRST 8'h77
`define SPICM_MASK_CTRL_SEC   8'hc7
`define SPICM_LAST_BIT        3'h7

`endif

// >>> spicm_pkg.sv
// Types shared by the SPI client block.
package spicm_pkg;

  // ========================================================================
  // Pins seen from the block.
  typedef struct packed {
    logic sck;
    logic selN;
    logic mosi;
  } spicm_pin_in_t;

  typedef struct packed {
    logic misoOut;
    logic misoOeN;
  } spicm_pin_out_t;

  // ========================================================================
  // Operating state of the serial engine.
  typedef enum logic [1:0] {
    SPICM_IDLE = 2'b00,
    SPICM_SEL  = 2'b01,
    SPICM_HOST = 2'b10
  } spicm_state_t;

endpackage

// >>> spicm_core.sv
// SPI client engine with host select fallback and an APB register port.
`timescale 1ns/10ps
`include "spicm_cfg.svh"

module spicm_core #(
  parameter int DataW = 8
) (
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // SPI pins
  input  wire spicm_pkg::spicm_pin_in_t  pinIn,
  output spicm_pkg::spicm_pin_out_t      pinOut,
  // Status
  output logic                       hostActive
);
  import spicm_pkg::*;

  // ========================================================================
  // Elaboration check: the engine is built around one byte.
  if (DataW != 8) begin : gBadWidth
    $error("spicm_core supports DataW of 8 only");
  end

  // Put one bit into a byte at the end chosen by the order bit.
  function automatic logic [7:0] shiftIn(input logic [7:0] cur,
                                         input logic       b,
                                         input logic       lsbFirst);
    shiftIn = lsbFirst ? {b, cur[7:1]} : {cur[6:0], b};
  endfunction

  // The bit presented first for the chosen order.
  function automatic logic headBit(input logic [7:0] cur,
                                   input logic       lsbFirst);
    headBit = lsbFirst ? cur[0] : cur[7];
  endfunction

  // ========================================================================
  // Registers and state.
  logic [7:0]   controlFirst_q;
  logic [7:0]   controlSecond_q;
  logic [1:0]   pinDir_q;
  logic [2:0]   sckSync_q;
  logic [1:0]   selSync_q;
  logic [1:0]   mosiSync_q;
  spicm_state_t state_q;
  spicm_state_t state_d;
  logic [2:0]   bitCnt_q;
  logic         pending_q;
  logic [7:0]   rxShift_q;
  logic [7:0]   txShift_q;
  logic [7:0]   rxData_q;
  logic [7:0]   txBuf_q;
  logic         bufFull_q;
  logic         shLoaded_q;
  logic         sentAll_q;
  logic         doneD1_q;
  logic         doneD2_q;
  logic         ifFlag_q;
  logic         wrcolFlag_q;
  logic         rxcFlag_q;
  logic         txcFlag_q;
  logic [31:0]  prdata_q;
  logic         misoOut_q;
  logic         misoOeN_q;

  // Decoded controls.
  logic       enable;
  logic       hostBit;
  logic       lsbFirst;
  logic       cpol;
  logic       cpha;
  logic       selDisable;
  logic       waitRx;
  logic       buffered_mode_enable;
  logic       selIsOut;
  logic       misoIsOut;
  logic       selHigh;
  logic       sckRise;
  logic       sckFall;
  logic       leadEdge;
  logic       trailEdge;
  logic       sampleEdge;
  logic       launchEdge;
  logic       selected;
  logic       busy;
  logic       byteDone;
  logic [7:0] newRx;
  logic       fallback;
  logic       promote;
  logic       access;
  logic       setup;
  logic [5:0] idx;
  logic       mapped;
  logic       dataWr;
  logic       flagWr;
  logic       txBufEmpty;
  logic [7:0] flagByte;

  assign enable     = controlFirst_q[`SPICM_BIT_ENABLE];
  assign hostBit    = controlFirst_q[`SPICM_BIT_HOST];
  assign lsbFirst   = controlFirst_q[`SPICM_BIT_ORDER];
  assign cpha       = controlSecond_q[`SPICM_BIT_MODE_LO];
  assign cpol       = controlSecond_q[`SPICM_BIT_MODE_LO + 1];
  assign selDisable = controlSecond_q[`SPICM_BIT_SEL_DISABLE];
  assign waitRx     = controlSecond_q[`SPICM_BIT_WAIT_RX];
  assign buffered_mode_enable      = controlSecond_q[`SPICM_BIT_BUF_EN];
  assign selIsOut   = pinDir_q[`SPICM_BIT_SEL_OUT];
  assign misoIsOut  = pinDir_q[`SPICM_BIT_MISO_OUT];
  assign txBufEmpty = ~bufFull_q;

  // ========================================================================
  // Pin synchronisers. Only the second stage and later are read, so a
  // metastable first stage never reaches the edge detector.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sckSync_q  <= 3'h0;
      selSync_q  <= 2'h3;
      mosiSync_q <= 2'h0;
    end else begin
      sckSync_q  <= {sckSync_q[1:0], pinIn.sck};
      selSync_q  <= {selSync_q[0], pinIn.selN};
      mosiSync_q <= {mosiSync_q[0], pinIn.mosi};
    end
  end

  // Edge detection on the synchronised clock; the host must keep each
  // phase over two cycles or edges merge and bits are lost.
  assign selHigh    = selSync_q[1];
  assign sckRise    = sckSync_q[1] & ~sckSync_q[2];
  assign sckFall    = ~sckSync_q[1] & sckSync_q[2];
  assign leadEdge   = cpol ? sckFall : sckRise;
  assign trailEdge  = cpol ? sckRise : sckFall;
  assign sampleEdge = cpha ? trailEdge : leadEdge;
  assign launchEdge = cpha ? leadEdge : trailEdge;

  // ========================================================================
  // Operating state. Pin directions never steer the client inputs.
  always_comb begin
    state_d = SPICM_IDLE;
    if (enable && hostBit) begin
      state_d = SPICM_HOST;
    end else if (enable && !selHigh) begin
      state_d = SPICM_SEL;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= SPICM_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  assign selected   = (state_q == SPICM_SEL) && !selHigh;
  assign hostActive = (state_q == SPICM_HOST);
  assign busy       = selected && (bitCnt_q != 3'h0 || pending_q);
  assign byteDone   = selected && sampleEdge && bitCnt_q == `SPICM_LAST_BIT;
  assign newRx      = shiftIn(rxShift_q, mosiSync_q[1], lsbFirst);

  // Select fallback: only an input select pin with select handling on.
  assign fallback = enable && hostBit && !selDisable
                    && !selIsOut && !selHigh;

  // Waiting mode: a deselected write climbs into the shift register.
  assign promote = buffered_mode_enable && waitRx && bufFull_q && !shLoaded_q
                   && selHigh && !hostBit;

  // ========================================================================
  // Bit counter and receive shifter; deselect wipes partial bytes.
  always_ff @(posedge clk_sys) begin
    if (rst || !selected) begin
      bitCnt_q  <= 3'h0;
      pending_q <= 1'b0;
      rxShift_q <= 8'h00;
    end else if (sampleEdge) begin
      rxShift_q <= newRx;
      bitCnt_q  <= bitCnt_q + 3'h1;
      pending_q <= (bitCnt_q != `SPICM_LAST_BIT);
    end else if (launchEdge && pending_q) begin
      pending_q <= 1'b0;
    end
  end

  // ========================================================================
  // Transmit shift register. It takes the received byte when nothing
  // waits, so the wait-zero dummy is the old shift content.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      txShift_q <= 8'h00;
    end else if (byteDone) begin
      if (buffered_mode_enable && bufFull_q) begin
        txShift_q <= txBuf_q;
      end else begin
        txShift_q <= newRx;
      end
    end else if (selected && launchEdge && pending_q) begin
      txShift_q <= lsbFirst ? {1'b0, txShift_q[7:1]}
                            : {txShift_q[6:0], 1'b0};
    end else if (dataWr && !buffered_mode_enable && !busy) begin
      txShift_q <= pwdata[7:0];
    end else if (promote) begin
      txShift_q <= txBuf_q;
    end
  end

  // ========================================================================
  // Transmit buffer; a write while it is full leaves it untouched.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      txBuf_q    <= 8'h00;
      bufFull_q  <= 1'b0;
      shLoaded_q <= 1'b0;
      sentAll_q  <= 1'b0;
    end else begin
      if (byteDone) begin
        sentAll_q  <= ~(buffered_mode_enable && bufFull_q);
        shLoaded_q <= buffered_mode_enable && bufFull_q;
      end else if (promote) begin
        shLoaded_q <= 1'b1;
      end
      if ((byteDone && buffered_mode_enable && bufFull_q) || promote) begin
        bufFull_q <= 1'b0;
      end else if (dataWr && buffered_mode_enable && txBufEmpty) begin
        txBuf_q   <= pwdata[7:0];
        bufFull_q <= 1'b1;
      end
    end
  end

  // Received byte and the delayed completion steps of buffered mode.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rxData_q <= 8'h00;
      doneD1_q <= 1'b0;
      doneD2_q <= 1'b0;
    end else begin
      if (byteDone) begin
        rxData_q <= newRx;
      end
      doneD1_q <= byteDone && buffered_mode_enable;
      doneD2_q <= doneD1_q && sentAll_q;
    end
  end

  // ========================================================================
  // Flags: write one to clear, and a set in the same cycle wins.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ifFlag_q    <= 1'b0;
      wrcolFlag_q <= 1'b0;
      rxcFlag_q   <= 1'b0;
      txcFlag_q   <= 1'b0;
    end else begin
      ifFlag_q <= (byteDone && !buffered_mode_enable) || fallback
                  || (ifFlag_q && !(flagWr
                      && pwdata[`SPICM_BIT_FLAG_HI]));
      wrcolFlag_q <= (dataWr && !buffered_mode_enable && busy)
                     || (wrcolFlag_q && !(flagWr
                         && pwdata[`SPICM_BIT_FLAG_MID]));
      rxcFlag_q <= doneD1_q
                   || (rxcFlag_q && !(flagWr
                       && pwdata[`SPICM_BIT_FLAG_HI]));
      txcFlag_q <= doneD2_q
                   || (txcFlag_q && !(flagWr
                       && pwdata[`SPICM_BIT_FLAG_MID]));
    end
  end

  // ========================================================================
  // Control registers. The fallback overrides a same-cycle write, so a
  // host bit set while another host holds select low is cleared a cycle later.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      controlFirst_q  <= `SPICM_RST_CTRL;
      controlSecond_q <= `SPICM_RST_CTRL;
      pinDir_q        <= `SPICM_RST_PIN_DIR;
    end else begin
      if (access && pwrite && idx == `SPICM_IDX_CTRL_FIRST) begin
        controlFirst_q <= pwdata[7:0] & `SPICM_MASK_CTRL_FIRST;
      end
      if (access && pwrite && idx == `SPICM_IDX_CTRL_SECOND) begin
        controlSecond_q <= pwdata[7:0] & `SPICM_MASK_CTRL_SEC;
      end
      if (access && pwrite && idx == `SPICM_IDX_PIN_DIR) begin
        pinDir_q <= pwdata[1:0];
      end
      if (fallback) begin
        controlFirst_q[`SPICM_BIT_HOST] <= 1'b0;
      end
    end
  end

  // ========================================================================
  // APB decode. Read data is captured in the setup cycle and the slave
  // answers in the first access cycle; unmapped offsets give an error.
  assign idx    = paddr[7:2];
  assign access = psel && penable;
  assign setup  = psel && !penable;
  assign mapped = (idx == `SPICM_IDX_CTRL_FIRST)
               || (idx == `SPICM_IDX_CTRL_SECOND)
               || (idx == `SPICM_IDX_FLAGS)
               || (idx == `SPICM_IDX_DATA)
               || (idx == `SPICM_IDX_PIN_DIR);
  assign dataWr = access && pwrite && idx == `SPICM_IDX_DATA;
  assign flagWr = access && pwrite && idx == `SPICM_IDX_FLAGS;
  assign pready  = 1'b1;
  assign pslverr = access && !mapped;
  assign prdata  = prdata_q;

  // Flag view depends on the buffer mode, as the bits share positions.
  always_comb begin
    flagByte = 8'h00;
    if (buffered_mode_enable) begin
      flagByte[`SPICM_BIT_FLAG_HI]  = rxcFlag_q;
      flagByte[`SPICM_BIT_FLAG_MID] = txcFlag_q;
      flagByte[`SPICM_BIT_FLAG_DRE] = txBufEmpty;
    end else begin
      flagByte[`SPICM_BIT_FLAG_HI]  = ifFlag_q;
      flagByte[`SPICM_BIT_FLAG_MID] = wrcolFlag_q;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prdata_q <= 32'h00000000;
    end else if (setup) begin
      case (idx)
        `SPICM_IDX_CTRL_FIRST:  prdata_q <= {24'h000000, controlFirst_q};
        `SPICM_IDX_CTRL_SECOND: prdata_q <= {24'h000000, controlSecond_q};
        `SPICM_IDX_FLAGS:       prdata_q <= {24'h000000, flagByte};
        `SPICM_IDX_DATA:        prdata_q <= {24'h000000, rxData_q};
        `SPICM_IDX_PIN_DIR:     prdata_q <= {30'h00000000, pinDir_q};
        default:                prdata_q <= 32'h00000000;
      endcase
    end
  end

  // ========================================================================
  // Data output pin; enable is low while driving, only when selected.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      misoOut_q <= 1'b0;
      misoOeN_q <= 1'b1;
    end else begin
      misoOut_q <= headBit(txShift_q, lsbFirst);
      misoOeN_q <= !(selected && misoIsOut);
    end
  end

  assign pinOut.misoOut = misoOut_q;
  assign pinOut.misoOeN = misoOeN_q;

endmodule

// >>> spicm_core_monitor.sv
// Port checker for the SPI client block.
`timescale 1ns/10ps
`include "spicm_cfg.svh"
module spicm_core_monitor (
  // Clock and reset
  input wire logic                      clk_sys,
  input wire logic                      rst,
  // APB
  input wire logic                      psel,
  input wire logic                      penable,
  input wire logic                      pwrite,
  input wire logic [7:0]                paddr,
  input wire logic [31:0]               pwdata,
  input wire logic [31:0]               prdata,
  input wire logic                      pready,
  input wire logic                      pslverr,
  // SPI pins and status
  input wire spicm_pkg::spicm_pin_in_t  pinIn,
  input wire spicm_pkg::spicm_pin_out_t pinOut,
  input wire logic                      hostActive
);
  import spicm_pkg::*;
  // ==========================================================================
  // Shadows of written settings, so pin checks know the configured mode.
  logic       wrAcc;
  logic       mapped;
  logic [5:0] idx;
  logic       enQ;
  logic       selDisQ;
  logic       selOutQ;
  logic       misoDirQ;
  assign idx    = paddr[7:2];
  assign wrAcc  = psel && penable && pwrite;
  assign mapped = idx inside {`SPICM_IDX_CTRL_FIRST, `SPICM_IDX_CTRL_SECOND,
                  `SPICM_IDX_FLAGS, `SPICM_IDX_DATA, `SPICM_IDX_PIN_DIR};
  // Pin direction shadow.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      selOutQ  <= 1'b0;
      misoDirQ <= 1'b0;
    end else if (wrAcc && idx == `SPICM_IDX_PIN_DIR) begin
      selOutQ  <= pwdata[`SPICM_BIT_SEL_OUT];
      misoDirQ <= pwdata[`SPICM_BIT_MISO_OUT];
    end
  end
  // Control shadow; the host bit is not kept, the port shows it.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      enQ     <= 1'b0;
      selDisQ <= 1'b0;
    end else if (wrAcc && idx == `SPICM_IDX_CTRL_FIRST) begin
      enQ <= pwdata[`SPICM_BIT_ENABLE];
    end else if (wrAcc && idx == `SPICM_IDX_CTRL_SECOND) begin
      selDisQ <= pwdata[`SPICM_BIT_SEL_DISABLE];
    end
  end
  // ==========================================================================
  // Checks. The select synchroniser has two stages, hence the short windows.
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  sequence sHostExposed;
    hostActive && !selDisQ && !selOutQ && !pinIn.selN;
  endsequence
  // A control write reaches the state one cycle late, so the cycle right
  // after a write is left out of the host kept and rearm checks.
  sequence sHostShielded;
    hostActive && (selDisQ || selOutQ) && !wrAcc && !$past(wrAcc);
  endsequence
  a_host_fallback: assert property (sHostExposed |-> ##[1:5] !hostActive)
    else $error("Host mode kept after select went low.");
  a_host_kept: assert property (sHostShielded |=> hostActive)
    else $error("Host mode lost while select was unused.");
  a_host_rearm: assert property (!hostActive && !wrAcc
    && !$past(wrAcc) |=> !hostActive)
    else $error("Host mode returned without a write.");
  a_miso_release: assert property (pinIn.selN [*5] |-> pinOut.misoOeN)
    else $error("MISO driven while deselected.");
  a_miso_dir: assert property (!misoDirQ [*2] |-> pinOut.misoOeN)
    else $error("MISO driven while set as input.");
  a_miso_drive: assert property ((enQ && misoDirQ && !hostActive
    && !pinIn.selN) [*6] |-> !pinOut.misoOeN)
    else $error("MISO not driven while selected.");
  a_ready_now: assert property (psel && penable |-> pready)
    else $error("Access phase not answered at once.");
  a_err_unmapped: assert property (psel && penable && !mapped
    |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("Unmapped access not refused.");
  a_ok_mapped: assert property (psel && penable && mapped |-> !pslverr)
    else $error("Mapped access refused.");
  a_rdata_hold: assert property ((!psel || penable) |=> $stable(prdata))
    else $error("Read data changed outside a setup cycle.");
endmodule

bind spicm_core spicm_core_monitor u_mon (
  .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pinIn(pinIn), .pinOut(pinOut),
  .hostActive(hostActive));

// >>> spicm_host_model.sv
// Behavioural external SPI host for the client block.
`timescale 1ns/10ps
module spicm_host_model (
  // Link outputs
  output logic      sck,
  output logic      selN,
  output logic      mosi,
  // Link input
  input  wire logic miso
);
  // ==========================================================================
  // Idle: select released, clock parked, no frame in flight.
  initial begin
    sck  = 1'b0;
    selN = 1'b1;
    mosi = 1'b0;
  end
  // Select alone, no clock; the wait covers the client's input stages.
  task automatic sel(input logic v);
    selN = v;
    #300;
  endtask
  // One frame of nbits; fewer than eight aborts the byte by deselecting.
  // Miso is read 75 ns after the sampling edge, since the client answers
  // several system cycles late; it is still valid until the next launch.
  task automatic xfer(input logic [7:0] tx, input logic [1:0] mode,
                      input logic lsb, input int nbits,
                      output logic [7:0] rx);
    int i;
    int k;
    rx = 8'h00;
    sck = mode[1];
    #200;
    selN = 1'b0;
    #107;
    for (i = 0; i < nbits; i++) begin
      k = lsb ? i : 7 - i;
      if (mode[0]) sck = ~sck;
      mosi = tx[k];
      #100;
      sck = ~sck;
      #75;
      rx[k] = miso;
      #25;
      if (!mode[0]) sck = ~sck;
    end
    #200;
    mosi = ~mosi; // A released line shows the inverse of its last level.
    selN = 1'b1;
    #300;
  endtask
endmodule

// >>> spicm_core_tb.sv
// Self-checking testbench for the SPI client block.
`timescale 1ns/10ps
`include "spicm_cfg.svh"
module spicm_core_tb;
  import spicm_pkg::*;
  // ==========================================================================
  // Register byte addresses, four times the index.
  localparam logic [7:0] ACtl1 = {`SPICM_IDX_CTRL_FIRST, 2'b00};
  localparam logic [7:0] ACtl2 = {`SPICM_IDX_CTRL_SECOND, 2'b00};
  localparam logic [7:0] AFlg  = {`SPICM_IDX_FLAGS, 2'b00};
  localparam logic [7:0] ADat  = {`SPICM_IDX_DATA, 2'b00};
  localparam logic [7:0] ADir  = {`SPICM_IDX_PIN_DIR, 2'b00};
  logic           clk_sys = 1'b0;
  logic           rst     = 1'b1;
  logic           psel;
  logic           penable;
  logic           pwrite;
  logic [7:0]     paddr;
  logic [31:0]    pwdata;
  logic [31:0]    prdata;
  logic           pready;
  logic           pslverr;
  logic           hostActive;
  spicm_pin_in_t  pinIn;
  spicm_pin_out_t pinOut;
  logic           hSck;
  logic           hSelN;
  logic           hMosi;
  logic           misoLine;
  logic           lastMiso = 1'b0;
  logic [31:0]    rdv;
  logic           errv;
  logic [7:0]     rx;
  logic [7:0]     d;
  int             i;
  int             numErrors = 0;
  int             checks = 0;
  // Clock; a released MISO line shows the inverse of its last level.
  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (!pinOut.misoOeN) lastMiso <= pinOut.misoOut;
  assign misoLine = pinOut.misoOeN ? ~lastMiso : pinOut.misoOut;
  assign pinIn    = '{sck: hSck, selN: hSelN, mosi: hMosi};
  spicm_core dut (.clk_sys(clk_sys), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pinIn(pinIn),
    .pinOut(pinOut), .hostActive(hostActive));
  spicm_host_model host (.sck(hSck), .selN(hSelN), .mosi(hMosi),
    .miso(misoLine));
  // ==========================================================================
  // Verdict and bus tasks.
  task automatic endSim();
    $display("Checks %0d mismatches %0d", checks, numErrors);
    if (numErrors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // One APB transfer; the wait for pready is bounded.
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] v);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, v};
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rdv     = prdata;
    errv    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      numErrors++;
      $display("Error pready expected 1 seen %b", pready);
      endSim();
    end
  endtask
  task automatic cmp8(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      numErrors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp1(input string nm, input logic e, input logic g);
    cmp8(nm, {7'h0, e}, {7'h0, g});
  endtask
  task automatic cmpRd(input string nm, input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    cmp8(nm, e, rdv[7:0]);
  endtask
  task automatic cmpFlg(input logic [7:0] m, input logic [7:0] e);
    apb(1'b0, AFlg, 8'h00);
    cmp8("flags", e, rdv[7:0] & m);
  endtask
  // ==========================================================================
  // Guard against a hang.
  initial begin
    #2000000;
    numErrors++;
    $display("Error run expected finish seen timeout");
    endSim();
  end
  // Main sequence.
  initial begin
    psel    <= 1'b0;
    penable <= 1'b0;
    pwrite  <= 1'b0;
    paddr   <= 8'h00;
    pwdata  <= 32'h0;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    cmpRd("ctrl_first", ACtl1, 8'h00);
    cmpRd("ctrl_second", ACtl2, 8'h00);
    cmpRd("pin_dir", ADir, 8'h00);
    cmpRd("unmapped", 8'h08, 8'h00);
    cmp1("pslverr", 1'b1, errv);
    $display("Test reset done");
    apb(1'b1, ACtl1, 8'h01);
    host.sel(1'b0);
    cmp1("misoOeN", 1'b1, pinOut.misoOeN);
    apb(1'b1, ADir, 8'h02);
    repeat (4) @(posedge clk_sys);
    cmp1("misoOeN", 1'b0, pinOut.misoOeN);
    host.sel(1'b1);
    cmp1("misoOeN", 1'b1, pinOut.misoOeN);
    apb(1'b1, ADat, 8'h43);
    fork
      host.xfer(8'ha5, 2'd0, 1'b0, 8, rx);
      begin
        repeat (60) @(posedge clk_sys);
        apb(1'b1, ADat, 8'h45);
      end
    join
    cmp8("rx", 8'h43, rx);
    apb(1'b0, AFlg, 8'h00);
    cmp8("flags", 8'hc0, rdv[7:0] & 8'hc0);
    cmpRd("data", ADat, 8'ha5);
    apb(1'b1, AFlg, 8'hc0);
    apb(1'b1, ADat, 8'h3c);
    host.xfer(8'h99, 2'd0, 1'b0, 4, rx);
    apb(1'b0, AFlg, 8'h00);
    cmp8("flags", 8'h00, rdv[7:0] & 8'hc0);
    apb(1'b1, ADat, 8'h3c);
    host.xfer(8'h5a, 2'd0, 1'b0, 8, rx);
    cmp8("rx", 8'h3c, rx);
    cmpRd("data", ADat, 8'h5a);
    $display("Test normal done");
    // Every mode with both bit orders; only the value db (mode 1, lsb first) is a palindrome.
    for (i = 0; i < 8; i++) begin
      d = 8'h1d + 8'(i) * 8'h26;
      apb(1'b1, ACtl1, {1'b0, i[2], 6'h01});
      apb(1'b1, ACtl2, {6'h0, i[1:0]});
      apb(1'b1, ADat, d);
      host.xfer(~d, i[1:0], i[2], 8, rx);
      cmp8("rx", d, rx);
      cmpRd("data", ADat, ~d);
    end
    $display("Test modes done");
    apb(1'b1, ACtl1, 8'h01);
    apb(1'b1, ACtl2, 8'h80);
    apb(1'b1, AFlg, 8'hc0);
    apb(1'b0, AFlg, 8'h00);
    cmp1("empty", 1'b1, rdv[5]);
    apb(1'b1, ADat, 8'h43);
    apb(1'b0, AFlg, 8'h00);
    cmp1("empty", 1'b0, rdv[5]);
    apb(1'b1, ADat, 8'h45);
    host.xfer(8'h61, 2'd0, 1'b0, 8, rx);
    cmp8("dummy", 8'hd8, rx);
    apb(1'b0, AFlg, 8'h00);
    cmp8("flags", 8'ha0, rdv[7:0] & 8'he0);
    apb(1'b1, AFlg, 8'hc0);
    host.xfer(8'h62, 2'd0, 1'b0, 8, rx);
    cmp8("rx", 8'h43, rx);
    apb(1'b0, AFlg, 8'h00);
    cmp8("flags", 8'he0, rdv[7:0] & 8'he0);
    apb(1'b1, ACtl2, 8'hc0);
    apb(1'b1, ADat, 8'h46);
    apb(1'b1, ADat, 8'h47);
    host.xfer(8'h63, 2'd0, 1'b0, 8, rx);
    cmp8("rx", 8'h46, rx);
    host.xfer(8'h64, 2'd0, 1'b0, 8, rx);
    cmp8("rx", 8'h47, rx);
    $display("Test buffered done");
    apb(1'b1, ACtl2, 8'h00);
    apb(1'b1, ADir, 8'h00);
    apb(1'b1, AFlg, 8'hc0);
    apb(1'b1, ACtl1, 8'h21);
    repeat (2) @(posedge clk_sys);
    cmp1("hostActive", 1'b1, hostActive);
    host.sel(1'b0);
    cmp1("hostActive", 1'b0, hostActive);
    cmpRd("ctrl_first", ACtl1, 8'h01);
    apb(1'b0, AFlg, 8'h00);
    cmp1("flag", 1'b1, rdv[7]);
    host.sel(1'b1);
    apb(1'b1, ADir, 8'h01);
    apb(1'b1, ACtl1, 8'h21);
    host.sel(1'b0);
    cmp1("hostActive", 1'b1, hostActive);
    host.sel(1'b1);
    apb(1'b1, ADir, 8'h00);
    apb(1'b1, ACtl2, 8'h04);
    host.sel(1'b0);
    cmp1("hostActive", 1'b1, hostActive);
    host.sel(1'b1);
    $display("Test host done");
    endSim();
  end
endmodule
